// file: core/cssq_sequencer.sv
// Clock source start-up sequencer with AXI4-Lite register access
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "cssq_regs.svh"
module cssq_sequencer #(
	parameter int CW = 16,
	parameter int AW = 8,
	parameter int TOUT_LONG = `CSSQ_TOUT_LONG,
	parameter int WAKE_16K = `CSSQ_WAKE_16K,
	parameter int WAKE_32K = `CSSQ_WAKE_32K
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic other_reset_active,
	input wire logic wdt_osc,
	input wire logic osc_in,
	input wire logic wake_event,
	output logic internal_reset,
	output logic cpu_clk_en,
	output logic adc_clk_en,
	output logic [2:0] clk_source,
	output logic [2:0] osc_range_mode,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		cssq_pkg::cssq_state_type state;
		logic [6:0] fuse;
		logic [6:0] act;
		logic quiet;
		logic from_wake;
		logic wdt_q;
		logic osc_q;
		logic [2:0] div_cnt;
		logic cpu_en;
		logic adc_en;
		logic int_rst;
		logic to_start;
		logic su_start;
		logic [CW-1:0] su_target;
		logic aw_v;
		logic [AW-1:0] aw_a;
		logic w_v;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic b_v;
		logic [1:0] b_r;
		logic r_v;
		logic [31:0] r_d;
		logic [1:0] r_r;
	} cssq_seq_state_type;

	cssq_seq_state_type st;
	cssq_seq_state_type next_st;

	cssq_pkg::cssq_src_type dec_src;
	cssq_pkg::cssq_tout_type dec_tout;
	logic [2:0] dec_range;
	logic [CW-1:0] dec_wake;
	logic dec_invalid;
	logic [CW-1:0] to_target;
	logic wdt_tick;
	logic osc_tick;
	logic div_tick;

	cssq_cnt_if #(.CW(CW)) to_bus ();
	cssq_cnt_if #(.CW(CW)) su_bus ();

	// Only the latched copy is decoded, so a fuse write mid-run waits
	// for the next reset, as real fuses would
	cssq_fuse_decode #(
		.CW(CW),
		.WAKE_16K(WAKE_16K),
		.WAKE_32K(WAKE_32K)
	) u_decode (
		.fuses(st.act),
		.source(dec_src),
		.range_mode(dec_range),
		.tout(dec_tout),
		.wake_count(dec_wake),
		.invalid(dec_invalid)
	);

	always_comb begin
		case (dec_tout)
			cssq_pkg::TO_SHORT: to_target = CW'(`CSSQ_TOUT_SHORT);
			cssq_pkg::TO_LONG: to_target = CW'(TOUT_LONG);
			default: to_target = '0;
		endcase
	end

	// Watchdog input is free running, independent of the chosen source
	assign wdt_tick = wdt_osc & ~st.wdt_q;
	assign osc_tick = osc_in & ~st.osc_q;
	assign div_tick = osc_tick & (st.act[`CSSQ_DIV_BIT] |
		(st.div_cnt == `CSSQ_DIV8_LAST));

	assign to_bus.start = st.to_start;
	assign to_bus.tick = wdt_tick;
	assign to_bus.target = to_target;
	assign su_bus.start = st.su_start;
	assign su_bus.tick = osc_tick;
	assign su_bus.target = st.su_target;

	cssq_edge_counter #(.CW(CW)) u_tout_cnt (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus(to_bus)
	);

	cssq_edge_counter #(.CW(CW)) u_start_cnt (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus(su_bus)
	);

	always_comb begin
		logic sleep_go;
		logic [AW-1:0] ra;
		logic [AW-1:0] wa;
		sleep_go = 1'b0;
		wa = {st.aw_a[AW-1:2], 2'h0};
		ra = {s_axi_araddr[AW-1:2], 2'h0};
		next_st = st;
		next_st.wdt_q = wdt_osc;
		next_st.osc_q = osc_in;
		next_st.to_start = 1'b0;
		next_st.su_start = 1'b0;
		if (osc_tick) begin
			next_st.div_cnt = st.div_cnt + 1'b1;
		end
		// Write address and data are taken in either order
		if (s_axi_awvalid && !st.aw_v) begin
			next_st.aw_v = 1'b1;
			next_st.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_v) begin
			next_st.w_v = 1'b1;
			next_st.w_d = s_axi_wdata;
			next_st.w_s = s_axi_wstrb;
		end
		if (st.aw_v && st.w_v && !st.b_v) begin
			next_st.aw_v = 1'b0;
			next_st.w_v = 1'b0;
			next_st.b_v = 1'b1;
			next_st.b_r = `CSSQ_RESP_OKAY;
			if (wa == AW'(`CSSQ_FUSE_OFS)) begin
				if (st.w_s[0]) begin
					next_st.fuse = st.w_d[6:0];
				end
			end else if (wa == AW'(`CSSQ_CTRL_OFS)) begin
				if (st.w_s[0]) begin
					next_st.quiet = st.w_d[`CSSQ_CTRL_QUIET];
					sleep_go = st.w_d[`CSSQ_CTRL_SLEEP];
				end
			end else if (wa != AW'(`CSSQ_STAT_OFS)) begin
				next_st.b_r = `CSSQ_RESP_SLVERR;
			end
		end
		if (st.b_v && s_axi_bready) begin
			next_st.b_v = 1'b0;
		end
		if (s_axi_arvalid && !st.r_v) begin
			next_st.r_v = 1'b1;
			next_st.r_r = `CSSQ_RESP_OKAY;
			if (ra == AW'(`CSSQ_FUSE_OFS)) begin
				next_st.r_d = {25'h0, st.fuse};
			end else if (ra == AW'(`CSSQ_CTRL_OFS)) begin
				next_st.r_d = {30'h0, st.quiet, 1'b0};
			end else if (ra == AW'(`CSSQ_STAT_OFS)) begin
				next_st.r_d = {20'h0, st.from_wake, dec_range,
					dec_src, dec_invalid, st.int_rst, st.state};
			end else begin
				next_st.r_d = 32'h0;
				next_st.r_r = `CSSQ_RESP_SLVERR;
			end
		end else if (st.r_v && s_axi_rready) begin
			next_st.r_v = 1'b0;
		end
		case (st.state)
			cssq_pkg::ST_HOLD: begin
				next_st.act = st.fuse;
				// Leave only once the latched copy is current, else a
				// short hold would judge the previous configuration
				if (!other_reset_active && st.act == st.fuse) begin
					if (dec_invalid) begin
						next_st.state = cssq_pkg::ST_BAD;
					end else begin
						next_st.state = cssq_pkg::ST_TIMEOUT;
						next_st.to_start = 1'b1;
					end
				end
			end
			cssq_pkg::ST_TIMEOUT: begin
				if (!st.to_start && to_bus.done) begin
					next_st.state = cssq_pkg::ST_SYNC;
				end
			end
			cssq_pkg::ST_SYNC: begin
				next_st.state = cssq_pkg::ST_STARTUP;
				next_st.su_start = 1'b1;
				next_st.su_target = CW'(dec_wake +
					CW'(`CSSQ_RST_EXTRA));
			end
			cssq_pkg::ST_STARTUP: begin
				if (!st.su_start && su_bus.done) begin
					next_st.state = cssq_pkg::ST_RUN;
					next_st.from_wake = 1'b0;
				end
			end
			cssq_pkg::ST_RUN: begin
				if (sleep_go) begin
					next_st.state = cssq_pkg::ST_SLEEP;
				end
			end
			cssq_pkg::ST_SLEEP: begin
				if (wake_event) begin
					// Supply is assumed good on wake, so no time-out
					next_st.state = cssq_pkg::ST_STARTUP;
					next_st.from_wake = 1'b1;
					next_st.su_start = 1'b1;
					next_st.su_target = dec_wake;
				end
			end
			cssq_pkg::ST_BAD: begin
				next_st.state = cssq_pkg::ST_BAD;
			end
			default: begin
				next_st.state = cssq_pkg::ST_HOLD;
			end
		endcase
		if (other_reset_active) begin
			next_st.state = cssq_pkg::ST_HOLD;
			next_st.from_wake = 1'b0;
		end
		next_st.int_rst = !(next_st.state == cssq_pkg::ST_RUN ||
			next_st.state == cssq_pkg::ST_SLEEP ||
			(next_st.state == cssq_pkg::ST_STARTUP &&
			next_st.from_wake));
		next_st.cpu_en = (st.state == cssq_pkg::ST_RUN) && !st.quiet &&
			div_tick;
		next_st.adc_en = (st.state == cssq_pkg::ST_RUN) &&
			osc_tick;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.state <= cssq_pkg::ST_HOLD;
			st.fuse <= `CSSQ_FUSE_RST;
			st.act <= `CSSQ_FUSE_RST;
			st.int_rst <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign internal_reset = st.int_rst;
	assign cpu_clk_en = st.cpu_en;
	assign adc_clk_en = st.adc_en;
	assign clk_source = dec_src;
	assign osc_range_mode = dec_range;
	assign s_axi_awready = !st.aw_v;
	assign s_axi_wready = !st.w_v;
	assign s_axi_bvalid = st.b_v;
	assign s_axi_bresp = st.b_r;
	assign s_axi_arready = !st.r_v;
	assign s_axi_rvalid = st.r_v;
	assign s_axi_rdata = st.r_d;
	assign s_axi_rresp = st.r_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_wake;
		st.state == cssq_pkg::ST_SLEEP ##1 st.state == cssq_pkg::ST_STARTUP;
	endsequence
	sequence s_sync_go;
		st.state == cssq_pkg::ST_TIMEOUT ##1 st.state == cssq_pkg::ST_SYNC;
	endsequence

	property p_decode_lp;
		st.act[3] |-> dec_src == cssq_pkg::SRC_LP && dec_range == st.act[3:1];
	endproperty
	a_decode_lp: assert property (p_decode_lp)
		else $error("low power crystal decode wrong");

	property p_ext_count;
		st.act[3:0] == 4'h0 |-> dec_wake == CW'(`CSSQ_EXT_CK);
	endproperty
	a_ext_count: assert property (p_ext_count)
		else $error("external clock start-up count wrong");

	property p_short_tout;
		st.act[5:0] == 6'h10 |-> to_target == CW'(`CSSQ_TOUT_SHORT);
	endproperty
	a_short_tout: assert property (p_short_tout)
		else $error("short time-out target wrong");

	property p_lp_long;
		st.act[5:0] == 6'h18 |-> to_target == CW'(TOUT_LONG);
	endproperty
	a_lp_long: assert property (p_lp_long)
		else $error("low power crystal long time-out wrong");

	property p_timeout_holds;
		st.state == cssq_pkg::ST_TIMEOUT |-> st.int_rst;
	endproperty
	a_timeout_holds: assert property (p_timeout_holds)
		else $error("internal reset dropped during time-out");

	property p_bad_holds;
		st.state == cssq_pkg::ST_BAD |-> st.int_rst && !st.cpu_en;
	endproperty
	a_bad_holds: assert property (p_bad_holds)
		else $error("reserved source released reset");

	property p_sync_stage;
		s_sync_go |-> $past(to_bus.done) && !st.su_start ##1
			st.state == cssq_pkg::ST_STARTUP && st.su_start;
	endproperty
	a_sync_stage: assert property (p_sync_stage)
		else $error("start-up counter not begun one cycle after sync");

	property p_reset_seq;
		s_sync_go |=> st.su_target == CW'(dec_wake + CW'(`CSSQ_RST_EXTRA));
	endproperty
	a_reset_seq: assert property (p_reset_seq)
		else $error("reset start-up count lacks the extra cycles");

	property p_wake_skip;
		s_wake |-> !st.int_rst && st.su_target == dec_wake &&
			st.from_wake;
	endproperty
	a_wake_skip: assert property (p_wake_skip)
		else $error("wake applied time-out or wrong count");

	property p_run_after_count;
		$rose(st.state == cssq_pkg::ST_RUN) |-> $past(su_bus.done);
	endproperty
	a_run_after_count: assert property (p_run_after_count)
		else $error("run entered before start-up count elapsed");

	property p_div8;
		st.cpu_en && !st.act[`CSSQ_DIV_BIT] |-> st.div_cnt == 3'h0;
	endproperty
	a_div8: assert property (p_div8)
		else $error("divided clock enable off its eighth edge");

	property p_quiet_adc;
		$past(st.quiet) && $past(st.state) == cssq_pkg::ST_RUN
			|-> !st.cpu_en;
	endproperty
	a_quiet_adc: assert property (p_quiet_adc)
		else $error("processor clock ran during quiet mode");
endmodule : cssq_sequencer

// file: core/cssq_regs.svh
// Register offsets, field positions, reset values and start-up counts
`ifndef CSSQ_REGS_SVH
`define CSSQ_REGS_SVH
`define CSSQ_FUSE_OFS 8'h00
`define CSSQ_CTRL_OFS 8'h04
`define CSSQ_STAT_OFS 8'h08
`define CSSQ_SEL_LSB 0
`define CSSQ_SUT_LSB 4
`define CSSQ_DIV_BIT 6
`define CSSQ_CTRL_SLEEP 0
`define CSSQ_CTRL_QUIET 1
`define CSSQ_FUSE_RST 7'h22
`define CSSQ_TOUT_SHORT 512
`define CSSQ_TOUT_LONG 8192
`define CSSQ_WAKE_258 258
`define CSSQ_WAKE_1K 1024
`define CSSQ_WAKE_16K 16384
`define CSSQ_WAKE_32K 32768
`define CSSQ_EXT_CK 6
`define CSSQ_RC_CK 6
`define CSSQ_RST_EXTRA 14
`define CSSQ_DIV8_LAST 3'h7
`define CSSQ_RESP_OKAY 2'h0
`define CSSQ_RESP_SLVERR 2'h2
`endif

// file: core/cssq_pkg.sv
// Types shared by the clock start-up sequencer
package cssq_pkg;
	typedef enum logic [2:0] {SRC_LP, SRC_FS, SRC_LF, SRC_RC128, SRC_RC,
		SRC_EXT, SRC_RSVD} cssq_src_type;
	typedef enum logic [2:0] {ST_HOLD, ST_TIMEOUT, ST_SYNC, ST_STARTUP,
		ST_RUN, ST_SLEEP, ST_BAD} cssq_state_type;
	typedef enum logic [1:0] {TO_NONE, TO_SHORT, TO_LONG} cssq_tout_type;
endpackage : cssq_pkg

// file: core/cssq_cnt_if.sv
// Start, tick, target and done of one start-up counter
`timescale 1ns/100ps
interface cssq_cnt_if #(parameter int CW = 16);
	logic start;
	logic tick;
	logic [CW-1:0] target;
	logic done;
	modport ctl (output start, output tick, output target, input done);
	modport cnt (input start, input tick, input target, output done);
endinterface : cssq_cnt_if

// file: core/cssq_edge_counter.sv
// Counts oscillator edges from a start pulse up to a target
`timescale 1ns/100ps
module cssq_edge_counter #(parameter int CW = 16) (
	input wire logic ref_clk,
	input wire logic rst,
	cssq_cnt_if.cnt bus
);
	typedef struct packed {
		logic [CW-1:0] count;
		logic busy;
		logic done;
	} cssq_cnt_state_type;
	cssq_cnt_state_type st;
	cssq_cnt_state_type next_st;

	always_comb begin
		next_st = st;
		if (bus.start) begin
			next_st.count = '0;
			next_st.busy = 1'b1;
			next_st.done = 1'b0;
		end else if (st.busy) begin
			if (st.count >= bus.target) begin
				next_st.done = 1'b1;
				next_st.busy = 1'b0;
			end else if (bus.tick) begin
				next_st.count = st.count + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.done = st.done;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_done_reach;
		$rose(st.done) |-> $past(st.count) >= $past(bus.target);
	endproperty
	a_done_reach: assert property (p_done_reach)
		else $error("counter done before target reached");

	property p_count_hold;
		st.busy && !bus.start && !bus.tick && !st.done
			|=> st.count == $past(st.count);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("counter moved without an oscillator edge");
endmodule : cssq_edge_counter

// file: core/cssq_fuse_decode.sv
// Decodes the stored fuse bits into source, range and start-up counts
`timescale 1ns/100ps
`include "cssq_regs.svh"
module cssq_fuse_decode #(
	parameter int CW = 16,
	parameter int WAKE_16K = `CSSQ_WAKE_16K,
	parameter int WAKE_32K = `CSSQ_WAKE_32K
) (
	input wire logic [6:0] fuses,
	output cssq_pkg::cssq_src_type source,
	output logic [2:0] range_mode,
	output cssq_pkg::cssq_tout_type tout,
	output logic [CW-1:0] wake_count,
	output logic invalid
);
	logic [3:0] sel;
	logic [1:0] sut;
	logic variant;

	assign sel = fuses[`CSSQ_SEL_LSB +: 4];
	assign sut = fuses[`CSSQ_SUT_LSB +: 2];
	assign variant = sel[0];

	always_comb begin
		source = cssq_pkg::SRC_RSVD;
		range_mode = 3'h0;
		tout = cssq_pkg::TO_NONE;
		wake_count = CW'(`CSSQ_EXT_CK);
		invalid = 1'b0;
		if (sel[3] || sel[3:1] == 3'h3) begin
			// Full swing shares the low power start-up table
			source = sel[3] ? cssq_pkg::SRC_LP : cssq_pkg::SRC_FS;
			if (sel[3]) begin
				range_mode = sel[3:1];
			end
			if (!variant) begin
				wake_count = sut[1] ? CW'(`CSSQ_WAKE_1K) :
					CW'(`CSSQ_WAKE_258);
			end else begin
				wake_count = (sut == 2'h0) ? CW'(`CSSQ_WAKE_1K) :
					CW'(WAKE_16K);
			end
			case ({variant, sut})
				3'h0, 3'h3, 3'h6: tout = cssq_pkg::TO_SHORT;
				3'h1, 3'h4, 3'h7: tout = cssq_pkg::TO_LONG;
				default: tout = cssq_pkg::TO_NONE;
			endcase
		end else if (sel[3:1] == 3'h2) begin
			source = cssq_pkg::SRC_LF;
			wake_count = variant ? CW'(WAKE_32K) : CW'(`CSSQ_WAKE_1K);
			case (sut)
				2'h0: tout = cssq_pkg::TO_NONE;
				2'h1: tout = cssq_pkg::TO_SHORT;
				2'h2: tout = cssq_pkg::TO_LONG;
				default: invalid = 1'b1;
			endcase
		end else if (sel == 4'h1) begin
			invalid = 1'b1;
		end else begin
			if (sel == 4'h3) begin
				source = cssq_pkg::SRC_RC128;
			end else if (sel == 4'h2) begin
				source = cssq_pkg::SRC_RC;
			end else begin
				source = cssq_pkg::SRC_EXT;
			end
			wake_count = (sel == 4'h0) ? CW'(`CSSQ_EXT_CK) :
				CW'(`CSSQ_RC_CK);
			tout = (sut == 2'h0) ? cssq_pkg::TO_NONE :
				(sut == 2'h1) ? cssq_pkg::TO_SHORT : cssq_pkg::TO_LONG;
		end
	end
endmodule : cssq_fuse_decode

// file: sim/cssq_osc_model.sv
// Free-running watchdog and selected oscillator models
`timescale 1ns/100ps
module cssq_osc_model #(
	parameter int WDT_HALF = 2
) (
	input wire logic ref_clk,
	input wire logic [3:0] osc_half,
	output logic wdt_osc,
	output logic osc_in
);
	logic [3:0] wdt_cnt = 4'h0;
	logic [3:0] osc_cnt = 4'h0;
	logic wdt_q = 1'b0;
	logic osc_q = 1'b0;
	// Watchdog never stops, whatever source is picked
	always @(posedge ref_clk) begin
		if (wdt_cnt >= 4'(WDT_HALF - 1)) begin
			wdt_cnt <= 4'h0;
			wdt_q <= ~wdt_q;
		end else begin
			wdt_cnt <= wdt_cnt + 4'h1;
		end
	end
	// A larger half period gives a slow oscillator
	always @(posedge ref_clk) begin
		if (osc_cnt >= osc_half - 4'h1) begin
			osc_cnt <= 4'h0;
			osc_q <= ~osc_q;
		end else begin
			osc_cnt <= osc_cnt + 4'h1;
		end
	end
	assign wdt_osc = wdt_q;
	assign osc_in = osc_q;
endmodule : cssq_osc_model

// file: sim/cssq_tb.sv
// Self-checking bench for the clock start-up sequencer
`timescale 1ns/100ps
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic other_reset_active = 1'b1;
	logic wdt_osc, osc_in, internal_reset, cpu_clk_en, adc_clk_en;
	logic wake_event = 1'b0;
	logic [3:0] osc_half = 4'h1;
	logic [2:0] clk_source, osc_range_mode;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [31:0] rd;
	logic [1:0] rs;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;

	always #5 ref_clk = ~ref_clk;

	// Long counts shortened so the whole run stays brief
	cssq_sequencer #(.TOUT_LONG(20), .WAKE_16K(40), .WAKE_32K(50))
	u_cssq_sequencer (.ref_clk(ref_clk), .rst(rst),
		.other_reset_active(other_reset_active), .wdt_osc(wdt_osc),
		.osc_in(osc_in), .wake_event(wake_event),
		.internal_reset(internal_reset), .cpu_clk_en(cpu_clk_en),
		.adc_clk_en(adc_clk_en), .clk_source(clk_source),
		.osc_range_mode(osc_range_mode), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	cssq_osc_model #(.WDT_HALF(2)) u_cssq_osc_model (.ref_clk(ref_clk),
		.osc_half(osc_half), .wdt_osc(wdt_osc), .osc_in(osc_in));

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	// A hung handshake or a reset that never releases ends here
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w || b) begin
			@(posedge ref_clk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				b = 1'b0;
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, rv;
		ar = 1'b1;
		rv = 1'b1;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (ar || rv) begin
			@(posedge ref_clk);
			if (ar && s_axi_arready === 1'b1) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				rv = 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
	endtask : axi_read

	// Store fuses, then pass through the hold state so they latch
	task automatic fuse_go(input logic [6:0] f);
		axi_write(8'h00, {25'h0, f}, rs);
		check(rs, 2'h0);
		@(posedge ref_clk);
		other_reset_active <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check(internal_reset, 1'b1);
		other_reset_active <= 1'b0;
	endtask : fuse_go

	// t watchdog edges every 4 cycles, o oscillator edges every 2
	task automatic boot(input logic [6:0] f, input int t, input int o);
		int n;
		logic ok;
		n = 0;
		fuse_go(f);
		while (internal_reset !== 1'b0) begin
			@(posedge ref_clk);
			n++;
		end
		ok = n >= 4 * t + 2 * o - 8 && n <= 4 * t + 2 * o + 16;
		check(ok, 1'b1);
	endtask : boot

	task automatic wake_chk(input int o);
		int e;
		logic p, low;
		axi_write(8'h04, 32'h1, rs);
		repeat (4) @(posedge ref_clk);
		wake_event <= 1'b1;
		e = 0;
		p = osc_in;
		low = 1'b1;
		do begin
			@(posedge ref_clk);
			if (osc_in && !p) e++;
			p = osc_in;
			if (internal_reset !== 1'b0) low = 1'b0;
		end while (adc_clk_en !== 1'b1);
		wake_event <= 1'b0;
		check(e >= o && e <= o + 3, 1'b1);
		check(low, 1'b1);
		axi_read(8'h08, rd, rs);
		check(rd[3:0], 4'h4);
	endtask : wake_chk

	// Clock enable counts over a fixed window; div is the expected ratio
	task automatic ratio(input int div);
		int c, a;
		logic ok;
		c = 0;
		a = 0;
		repeat (240) begin
			@(posedge ref_clk);
			if (cpu_clk_en === 1'b1) c++;
			if (adc_clk_en === 1'b1) a++;
		end
		check(a >= 100, 1'b1);
		if (div == 0) begin
			check(c, 0);
		end else begin
			ok = c * div >= a - div && c * div <= a + div;
			check(ok, 1'b1);
		end
	endtask : ratio

	function automatic logic [2:0] exp_src(input logic [3:0] c);
		if (c[3]) return 3'h0;
		if (c[2:1] == 2'b11) return 3'h1;
		if (c[2:1] == 2'b10) return 3'h2;
		case (c[1:0])
			2'b11: return 3'h3;
			2'b10: return 3'h4;
			2'b00: return 3'h5;
			default: return 3'h6;
		endcase
	endfunction : exp_src

	initial begin
		repeat (20) @(posedge ref_clk);
		check(internal_reset, 1'b1);
		check(clk_source, 3'h4);
		rst <= 1'b0;
		axi_read(8'h00, rd, rs);
		check(rd, 32'h22);
		boot(7'h22, 20, 20);
		ratio(8);
		axi_write(8'h04, 32'h2, rs);
		axi_read(8'h04, rd, rs);
		check(rd, 32'h2);
		ratio(0);
		axi_write(8'h04, 32'h0, rs);
		axi_read(8'h0c, rd, rs);
		check(rs, 2'h2);
		check(rd, 32'h0);
		axi_write(8'h10, 32'h1, rs);
		check(rs, 2'h2);
		axi_write(8'h08, 32'h0, rs);
		check(rs, 2'h0);
		// Every select code with every start-up code, divide fuse left off
		for (int i = 0; i < 64; i++) begin
			fuse_go({1'b1, i[5:0]});
			check(clk_source, exp_src(i[3:0]));
			check(osc_range_mode, i[3] ? i[3:1] : 3'h0);
		end
		fuse_go(7'h41);
		repeat (60) @(posedge ref_clk);
		check(internal_reset, 1'b1);
		axi_read(8'h08, rd, rs);
		check(rd[4:0], 5'h1e);
		boot(7'h40, 0, 20);
		ratio(1);
		boot(7'h4e, 512, 272);
		osc_half <= 4'h2;
		wake_chk(258);
		osc_half <= 4'h1;
		boot(7'h59, 0, 54);
		wake_chk(40);
		boot(7'h6a, 0, 1038);
		boot(7'h55, 512, 64);
		conclude();
	end
endmodule : tb
